// File: encoder_position_defines.vh
// object indices, field positions, reset values and capability defaults
// assumes inclusion by every design file of the position block
`ifndef ENCODER_POSITION_DEFINES_VH
`define ENCODER_POSITION_DEFINES_VH

////////////////////////////////////////////////////////////////////////////
// object indices
`define IDX_STORE 16'h1010
`define IDX_RESTORE 16'h1011
`define IDX_OP_PARAM 16'h6000
`define IDX_UNITS_REV 16'h6001
`define IDX_TOTAL_RANGE 16'h6002
`define IDX_PRESET 16'h6003
`define IDX_POSITION 16'h6004
`define IDX_OP_STATE 16'h6500
`define IDX_MAX_STEPS 16'h6501
`define IDX_MAX_TURNS 16'h6502
`define IDX_VERSION 16'h6507
`define IDX_OFFSET 16'h6509

////////////////////////////////////////////////////////////////////////////
// operating parameter word fields
`define OP_DIR_BIT 0
`define OP_DIAG_BIT 1
`define OP_SCALE_BIT 2
`define OP_MEASDIR_BIT 3
`define OP_RESET 16'h0004

////////////////////////////////////////////////////////////////////////////
// signatures for store and restore
`define SIG_STORE 32'h65766173
`define SIG_RESTORE 32'h64616f6c

////////////////////////////////////////////////////////////////////////////
// capability of this variant (nameplate values, plain defaults)
`define MAX_STEPS 32'h00002000
`define MAX_TURNS 32'h00001000
`define FULL_RANGE 32'h02000000
`define UNITS_REV_RESET 32'h00002000
`define TOTAL_RANGE_RESET 32'h02000000
`define PRESET_RESET 32'h00000000

////////////////////////////////////////////////////////////////////////////
// version word: software bytes are arbitrary, profile is 3.2
`define SW_MAJOR 8'h01
`define SW_MINOR 8'h00
`define PROFILE_MAJOR 8'h03
`define PROFILE_MINOR 8'h02

////////////////////////////////////////////////////////////////////////////
// divider length in cycles
`define DIV_STEPS 7'h40

`endif

// File: position_skid_buffer.v
// two-entry buffer between the position pipeline and the process data side
// assumes one clock, synchronous active-low reset
`include "encoder_position_defines.vh"

module position_skid_buffer (
    input wire clk,
    input wire nrst,
    input wire in_valid,
    output reg in_ready_r,
    input wire [31:0] in_data,
    output reg out_valid_r,
    input wire out_ready,
    output reg [31:0] out_data_r
);

reg [31:0] spare_r;
reg spare_valid_r;
reg [31:0] spare_nxt;
reg spare_valid_nxt;
reg [31:0] out_data_nxt;
reg out_valid_nxt;
wire push;
wire pop;

assign push = in_valid & in_ready_r;
assign pop = out_valid_r & out_ready;

////////////////////////////////////////////////////////////////////////////
// head register feeds the port, spare catches the word taken during a stall
always @* begin
    out_data_nxt = out_data_r;
    out_valid_nxt = out_valid_r;
    spare_nxt = spare_r;
    spare_valid_nxt = spare_valid_r;
    if (pop) begin
        if (spare_valid_r) begin
            out_data_nxt = spare_r;
            spare_valid_nxt = 1'b0;
        end else if (push) begin
            out_data_nxt = in_data;
        end else begin
            out_valid_nxt = 1'b0;
        end
    end else if (push) begin
        if (!out_valid_r) begin
            out_data_nxt = in_data;
            out_valid_nxt = 1'b1;
        end else begin
            spare_nxt = in_data;
            spare_valid_nxt = 1'b1;
        end
    end
end

always @(posedge clk) begin
    if (!nrst) begin
        out_data_r <= 32'h00000000;
        out_valid_r <= 1'b0;
        spare_r <= 32'h00000000;
        spare_valid_r <= 1'b0;
        in_ready_r <= 1'b1;
    end else begin
        out_data_r <= out_data_nxt;
        out_valid_r <= out_valid_nxt;
        spare_r <= spare_nxt;
        spare_valid_r <= spare_valid_nxt;
        in_ready_r <= !spare_valid_nxt;
    end
end

endmodule

// File: long_divider.v
// sequential 64 by 32 restoring divider, one quotient bit per cycle
// assumes a nonzero divisor and a quotient that fits in 32 bits
`include "encoder_position_defines.vh"

module long_divider (
    input wire clk,
    input wire nrst,
    input wire start,
    input wire [63:0] dividend,
    input wire [31:0] divisor,
    output reg done_r,
    output wire [31:0] quotient,
    output wire [31:0] remainder
);

reg [63:0] quo_r;
reg [32:0] rem_r;
reg [31:0] dsr_r;
reg [6:0] cnt_r;
reg busy_r;
wire [32:0] shifted;
wire take;

assign shifted = {rem_r[31:0], quo_r[63]};
assign take = shifted >= {1'b0, dsr_r};
assign quotient = quo_r[31:0];
assign remainder = rem_r[31:0];

always @(posedge clk) begin
    if (!nrst) begin
        quo_r <= 64'h0000000000000000;
        rem_r <= 33'h000000000;
        dsr_r <= 32'h00000000;
        cnt_r <= 7'h00;
        busy_r <= 1'b0;
        done_r <= 1'b0;
    end else begin
        done_r <= 1'b0;
        if (start) begin
            quo_r <= dividend;
            rem_r <= 33'h000000000;
            dsr_r <= divisor;
            cnt_r <= `DIV_STEPS;
            busy_r <= 1'b1;
        end else if (busy_r) begin
            rem_r <= take ? shifted - {1'b0, dsr_r} : shifted;
            quo_r <= {quo_r[62:0], take};
            cnt_r <= cnt_r - 7'h01;
            if (cnt_r == 7'h01) begin
                busy_r <= 1'b0;
                done_r <= 1'b1;
            end
        end
    end
end

endmodule

// File: encoder_position_scaling.v
// parameter objects and position value of an absolute rotary encoder
// assumes the raw count is below steps times turns and synchronous to clk;
// the object port is single-cycle request, answer one cycle later
//
// Summary of operation
// - bit 0 selects clockwise or counterclockwise counting
// - bit 2 set disables scaling, clear enables
// - bits 15..12, 11..4, 3, 1 do nothing
// - scaling uses units per turn and range
// - preset write makes present position equal preset
// - offset equals physical minus shown, refreshed by preset
// - position value read-only and streamed as process data
// - parameters persist only after a store request
// - version word: software bytes, profile 03h 02h
// - steps and turns capability words are fixed
// - status word mirrors parameters, reset 4h
// - store signature saves all application parameters
// - restore signature reloads factory values and saves
`include "encoder_position_defines.vh"

module encoder_position_scaling (
    input wire clk,
    input wire nrst,
    input wire [31:0] raw_count,
    input wire obj_req,
    input wire obj_we,
    input wire [15:0] obj_index,
    input wire [31:0] obj_wdata,
    output reg obj_ack_r,
    output reg obj_err_r,
    output reg [31:0] obj_rdata_r,
    output wire pos_valid,
    input wire pos_ready,
    output wire [31:0] pos_data,
    output reg store_req_r,
    output reg restore_done_r
);

localparam S_IDLE = 3'h0;
localparam S_DIV1 = 3'h1;
localparam S_DIV2 = 3'h2;
localparam S_FIX = 3'h3;
localparam S_PUSH = 3'h4;

reg [15:0] op_param_r;
reg [31:0] units_rev_r;
reg [31:0] total_range_r;
reg [31:0] preset_r;
reg [31:0] position_r;
reg [31:0] offset_r;
reg preset_pend_r;
reg [2:0] state_r;
reg div_start_r;
reg [63:0] div_dvd_r;
reg [31:0] div_dsr_r;
reg [31:0] phys_r;
reg [31:0] range_used_r;
reg [31:0] rd_val;
reg rd_ok;

wire div_done;
wire [31:0] div_quo;
wire [31:0] div_rem;
wire buf_ready;
wire scale_on;
wire [31:0] eff_units;
wire [31:0] eff_range;
wire [31:0] dir_count;
wire [63:0] product;
wire [31:0] shown;
wire wr;
wire rd;
wire wr_preset;
wire do_restore;
wire fix_clear;

////////////////////////////////////////////////////////////////////////////
// effective scaling parameters
// table polarity taken: a set bit turns scaling off, so reset 4h is native
assign scale_on = !op_param_r[`OP_SCALE_BIT];
// only bits 0 and 2 are ever looked at; the rest is stored, never decoded
assign eff_units = scale_on ? units_rev_r : `MAX_STEPS;
// a zero range would leave the divider a meaningless remainder, fall back to native
assign eff_range = (scale_on && total_range_r != 32'h00000000) ?
    total_range_r : `FULL_RANGE;
// counterclockwise mirrors the count inside the native range
assign dir_count = op_param_r[`OP_DIR_BIT] ?
    (`FULL_RANGE - 32'h00000001 - raw_count) : raw_count;
assign product = dir_count * eff_units;

// shown = physical minus offset, wrapped into the range
assign shown = (phys_r >= offset_r) ? (phys_r - offset_r) :
    (phys_r + range_used_r - offset_r);

////////////////////////////////////////////////////////////////////////////
// object access decode
assign wr = obj_req & obj_we;
assign rd = obj_req & !obj_we;
assign wr_preset = wr && obj_index == `IDX_PRESET;
assign do_restore = wr && obj_index == `IDX_RESTORE &&
    obj_wdata == `SIG_RESTORE;
assign fix_clear = (state_r == S_FIX) && preset_pend_r;

always @* begin
    rd_val = 32'h00000000;
    rd_ok = 1'b1;
    case (obj_index)
        `IDX_STORE: rd_val = `SIG_STORE;
        `IDX_RESTORE: rd_val = `SIG_RESTORE;
        `IDX_OP_PARAM: rd_val = {16'h0000, op_param_r};
        `IDX_UNITS_REV: rd_val = units_rev_r;
        `IDX_TOTAL_RANGE: rd_val = total_range_r;
        `IDX_PRESET: rd_val = preset_r;
        `IDX_POSITION: rd_val = position_r;
        `IDX_OP_STATE: rd_val = {16'h0000, op_param_r};
        `IDX_MAX_STEPS: rd_val = `MAX_STEPS;
        `IDX_MAX_TURNS: rd_val = `MAX_TURNS;
        `IDX_VERSION: rd_val = {`SW_MAJOR, `SW_MINOR,
            `PROFILE_MAJOR, `PROFILE_MINOR};
        `IDX_OFFSET: rd_val = offset_r;
        default: rd_ok = 1'b0;
    endcase
end

////////////////////////////////////////////////////////////////////////////
// parameter objects
// no value here survives power loss; the store pulse hands them to nvm
// reset reloads factory values, so an unsaved preset is simply gone
always @(posedge clk) begin
    if (!nrst) begin
        op_param_r <= `OP_RESET;
        units_rev_r <= `UNITS_REV_RESET;
        total_range_r <= `TOTAL_RANGE_RESET;
        preset_r <= `PRESET_RESET;
        preset_pend_r <= 1'b0;
        obj_ack_r <= 1'b0;
        obj_err_r <= 1'b0;
        obj_rdata_r <= 32'h00000000;
        store_req_r <= 1'b0;
        restore_done_r <= 1'b0;
    end else begin
        obj_ack_r <= 1'b0;
        obj_err_r <= 1'b0;
        store_req_r <= 1'b0;
        restore_done_r <= 1'b0;
        // a new preset in the same cycle as the pipeline takes the old
        // one keeps the flag set
        if (fix_clear && !wr_preset)
            preset_pend_r <= 1'b0;
        if (rd) begin
            obj_ack_r <= rd_ok;
            obj_err_r <= !rd_ok;
            obj_rdata_r <= rd_val;
        end
        if (wr) begin
            obj_ack_r <= 1'b1;
            case (obj_index)
                `IDX_OP_PARAM: op_param_r <= obj_wdata[15:0];
                `IDX_UNITS_REV: units_rev_r <= obj_wdata;
                `IDX_TOTAL_RANGE: total_range_r <= obj_wdata;
                `IDX_PRESET: begin
                    preset_r <= obj_wdata;
                    preset_pend_r <= 1'b1;
                end
                `IDX_STORE: begin
                    if (obj_wdata == `SIG_STORE)
                        store_req_r <= 1'b1;
                    else
                        obj_err_r <= 1'b1;
                end
                `IDX_RESTORE: begin
                    if (obj_wdata == `SIG_RESTORE) begin
                        op_param_r <= `OP_RESET;
                        units_rev_r <= `UNITS_REV_RESET;
                        total_range_r <= `TOTAL_RANGE_RESET;
                        preset_r <= `PRESET_RESET;
                        preset_pend_r <= 1'b0;
                        store_req_r <= 1'b1;
                        restore_done_r <= 1'b1;
                    end else begin
                        obj_err_r <= 1'b1;
                    end
                end
                default: obj_err_r <= 1'b1;
            endcase
            // unknown and read-only writes answer with ack and err together
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// position pipeline: count*units/steps, then modulo range, then offset
// changing scale or range while a preset stands leaves the old offset
// in place; reapply the preset afterwards
always @(posedge clk) begin
    if (!nrst) begin
        state_r <= S_IDLE;
        div_start_r <= 1'b0;
        div_dvd_r <= 64'h0000000000000000;
        div_dsr_r <= 32'h00000001;
        phys_r <= 32'h00000000;
        range_used_r <= `FULL_RANGE;
        offset_r <= 32'h00000000;
        position_r <= 32'h00000000;
    end else begin
        div_start_r <= 1'b0;
        case (state_r)
            S_IDLE: begin
                div_dvd_r <= product;
                div_dsr_r <= `MAX_STEPS;
                range_used_r <= eff_range;
                div_start_r <= 1'b1;
                state_r <= S_DIV1;
            end
            S_DIV1: begin
                if (div_done) begin
                    div_dvd_r <= {32'h00000000, div_quo};
                    div_dsr_r <= range_used_r;
                    div_start_r <= 1'b1;
                    state_r <= S_DIV2;
                end
            end
            S_DIV2: begin
                if (div_done) begin
                    phys_r <= div_rem;
                    state_r <= S_FIX;
                end
            end
            S_FIX: begin
                // the preset is assumed to lie inside the range
                if (preset_pend_r)
                    offset_r <= (phys_r >= preset_r) ? (phys_r - preset_r) :
                        (phys_r + range_used_r - preset_r);
                state_r <= S_PUSH;
            end
            S_PUSH: begin
                // a full buffer holds the pipeline here, no sample lost
                if (buf_ready) begin
                    position_r <= shown;
                    state_r <= S_IDLE;
                end
            end
            default: state_r <= S_IDLE;
        endcase
        if (do_restore)
            offset_r <= 32'h00000000;
    end
end

long_divider u_div (
    .clk(clk),
    .nrst(nrst),
    .start(div_start_r),
    .dividend(div_dvd_r),
    .divisor(div_dsr_r),
    .done_r(div_done),
    .quotient(div_quo),
    .remainder(div_rem)
);

////////////////////////////////////////////////////////////////////////////
// process data path
position_skid_buffer u_buf (
    .clk(clk),
    .nrst(nrst),
    .in_valid(state_r == S_PUSH),
    .in_ready_r(buf_ready),
    .in_data(shown),
    .out_valid_r(pos_valid),
    .out_ready(pos_ready),
    .out_data_r(pos_data)
);

endmodule

// File: encoder_position_scaling_props.sv
// concurrent checks on the object port and the process data output
// assumes binding onto the position block; one clock, nrst active low
`include "encoder_position_defines.vh"

module encoder_position_checker (
    input wire clk,
    input wire nrst,
    input wire [31:0] raw_count,
    input wire obj_req,
    input wire obj_we,
    input wire [15:0] obj_index,
    input wire [31:0] obj_wdata,
    input wire obj_ack_r,
    input wire obj_err_r,
    input wire [31:0] obj_rdata_r,
    input wire pos_valid,
    input wire pos_ready,
    input wire [31:0] pos_data,
    input wire store_req_r,
    input wire restore_done_r
);
    timeunit 1ns;
    timeprecision 100ps;
    reg [15:0] op_shadow_r;
    wire wr = obj_req && obj_we;
    wire rd = obj_req && !obj_we;
    wire rst_sig = obj_index == `IDX_RESTORE && obj_wdata == `SIG_RESTORE;
    wire ro_idx = obj_index == `IDX_POSITION || obj_index == `IDX_OP_STATE ||
        obj_index == `IDX_MAX_STEPS || obj_index == `IDX_MAX_TURNS ||
        obj_index == `IDX_VERSION || obj_index == `IDX_OFFSET;

    ////////////////////////////////////////////////////////////////////////
    // shadow of the parameter word, restore puts it back to 4h
    always @(posedge clk) begin
        if (!nrst) begin
            op_shadow_r <= `OP_RESET;
        end else if (wr && obj_index == `IDX_OP_PARAM) begin
            op_shadow_r <= obj_wdata[15:0];
        end else if (wr && rst_sig) begin
            op_shadow_r <= `OP_RESET;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    ////////////////////////////////////////////////////////////////////////
    a_ro_write_refused: assert property (
        wr && ro_idx |=> obj_ack_r && obj_err_r)
        else $error("write to read-only object not refused");
    a_version_low: assert property (
        rd && obj_index == `IDX_VERSION |=> obj_rdata_r[15:0] == 16'h0302)
        else $error("profile version bytes wrong");
    a_steps_fixed: assert property (
        rd && obj_index == `IDX_MAX_STEPS |=> obj_rdata_r == `MAX_STEPS)
        else $error("steps capability changed");
    a_turns_fixed: assert property (
        rd && obj_index == `IDX_MAX_TURNS |=> obj_rdata_r == `MAX_TURNS)
        else $error("turns capability changed");
    a_status_mirror: assert property (
        rd && obj_index == `IDX_OP_STATE
        |=> obj_rdata_r == {16'h0000, op_shadow_r})
        else $error("status word does not mirror parameters");
    a_param_readback: assert property (
        rd && obj_index == `IDX_OP_PARAM
        |=> obj_rdata_r == {16'h0000, op_shadow_r})
        else $error("parameter word readback wrong");
    a_store_pulse: assert property (
        wr && obj_index == `IDX_STORE && obj_wdata == `SIG_STORE
        |=> store_req_r && !obj_err_r)
        else $error("store signature gave no save");
    a_restore_pulse: assert property (
        wr && rst_sig |=> restore_done_r && store_req_r)
        else $error("restore did not reload and save");
    a_store_cause: assert property (
        store_req_r |-> $past(wr &&
        (obj_index == `IDX_STORE || obj_index == `IDX_RESTORE)))
        else $error("save without store request");
    a_pos_hold: assert property (
        pos_valid && !pos_ready |=> pos_valid && $stable(pos_data))
        else $error("process data word lost under stall");

    c_store: cover property (store_req_r);
    c_preset: cover property (wr && obj_index == `IDX_PRESET);
    c_stall: cover property (pos_valid && !pos_ready [*4]);
endmodule

bind encoder_position_scaling encoder_position_checker chk_u (
    .clk(clk), .nrst(nrst), .raw_count(raw_count), .obj_req(obj_req),
    .obj_we(obj_we), .obj_index(obj_index), .obj_wdata(obj_wdata),
    .obj_ack_r(obj_ack_r), .obj_err_r(obj_err_r),
    .obj_rdata_r(obj_rdata_r), .pos_valid(pos_valid),
    .pos_ready(pos_ready), .pos_data(pos_data),
    .store_req_r(store_req_r), .restore_done_r(restore_done_r)
);

// File: pd_consumer.sv
// cyclic process data consumer standing for the fieldbus master
// assumes registered valid and data from the position block
module pd_consumer (
    input wire clk,
    input wire nrst,
    input wire stall,
    input wire slow,
    input wire pos_valid,
    output reg pos_ready,
    input wire [31:0] pos_data,
    output reg [31:0] last_word,
    output reg [15:0] word_count
);
    timeunit 1ns;
    timeprecision 100ps;
    reg [1:0] phase_r;

    always @(posedge clk) begin
        if (!nrst) begin
            pos_ready <= 1'b0;
            phase_r <= 2'h0;
            last_word <= 32'h00000000;
            word_count <= 16'h0000;
        end else begin
            phase_r <= phase_r + 2'h1;
            // slow mode takes one word in four cycles, like a long bus cycle
            pos_ready <= !stall && (!slow || phase_r == 2'h3);
            if (pos_valid && pos_ready) begin
                last_word <= pos_data;
                word_count <= word_count + 16'h0001;
            end
        end
    end
endmodule

// File: encoder_position_scaling_tb.sv
// self-checking bench of the encoder position block
// assumes pd_consumer on the process data side and the bound checker
`include "encoder_position_defines.vh"

module encoder_position_scaling_tb;
    timeunit 1ns;
    timeprecision 100ps;
    // index and expected value after reset, then after restore
    localparam [383:0] RD = {16'h6000, 32'h00000004, 16'h6500, 32'h00000004,
        16'h6501, 32'h00002000, 16'h6502, 32'h00001000,
        16'h6507, 32'h01000302, 16'h1010, 32'h65766173,
        16'h1011, 32'h64616f6c, 16'h6509, 32'h00000000};
    localparam [239:0] RS = {16'h6000, 32'h00000004, 16'h6001, 32'h00002000,
        16'h6002, 32'h02000000, 16'h6003, 32'h00000000,
        16'h6509, 32'h00000000};
    localparam [95:0] RO = {16'h6004, 16'h6500, 16'h6501, 16'h6502,
        16'h6507, 16'h6509};
    reg clk, nrst, obj_req, obj_we, stall, slow;
    reg [15:0] obj_index;
    reg [31:0] obj_wdata, raw_count, rd;
    reg [1:0] fl, sv;
    wire obj_ack_r, obj_err_r, pos_valid, pos_ready;
    wire store_req_r, restore_done_r;
    wire [31:0] obj_rdata_r, pos_data, last_word;
    wire [15:0] word_count;
    integer err_count = 0;
    integer samples_checked = 0;
    integer i;

    encoder_position_scaling dut_u (.clk(clk), .nrst(nrst),
        .raw_count(raw_count), .obj_req(obj_req), .obj_we(obj_we),
        .obj_index(obj_index), .obj_wdata(obj_wdata),
        .obj_ack_r(obj_ack_r), .obj_err_r(obj_err_r),
        .obj_rdata_r(obj_rdata_r), .pos_valid(pos_valid),
        .pos_ready(pos_ready), .pos_data(pos_data),
        .store_req_r(store_req_r), .restore_done_r(restore_done_r));
    pd_consumer pd_u (.clk(clk), .nrst(nrst), .stall(stall), .slow(slow),
        .pos_valid(pos_valid), .pos_ready(pos_ready), .pos_data(pos_data),
        .last_word(last_word), .word_count(word_count));

    ////////////////////////////////////////////////////////////////////////
    task tally_and_finish;
        begin
            $display("checked %0d, mismatches %0d", samples_checked,
                err_count);
            if (err_count == 0 && samples_checked > 0) begin
                $display("Testbench passed");
            end else begin
                $display("Testbench failed");
            end
            $finish;
        end
    endtask
    task check(input [31:0] seen, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
            end
        end
    endtask
    // one-cycle request; answer is registered at the taking edge
    task acc(input we, input [15:0] idx, input [31:0] wd);
        begin
            @(posedge clk);
            #1;
            obj_req = 1'b1;
            obj_we = we;
            obj_index = idx;
            obj_wdata = wd;
            @(posedge clk);
            #1;
            obj_req = 1'b0;
            rd = obj_rdata_r;
            fl = {obj_ack_r, obj_err_r};
            sv = {restore_done_r, store_req_r};
        end
    endtask
    // skip buffered and in-flight words so the new setting has taken hold
    task wait_pos(input [31:0] exp);
        reg [15:0] target;
        integer n;
        begin
            target = word_count + 16'h0004;
            n = 0;
            while (word_count !== target && n < 3000) begin
                @(posedge clk);
                #1;
                n = n + 1;
            end
            if (n >= 3000)
                err_count = err_count + 1;
            check(last_word, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (40000) @(posedge clk);
        err_count = err_count + 1;
        tally_and_finish;
    end
    initial begin
        {nrst, obj_req, obj_we, stall, slow} = 5'h00;
        obj_index = 16'h0000;
        obj_wdata = 32'h00000000;
        raw_count = 32'h00012345;
        repeat (4) @(posedge clk);
        #1;
        nrst = 1'b1;
        for (i = 7; i >= 0; i = i - 1) begin
            acc(1'b0, RD[i*48+32 +: 16], 32'h00000000);
            check(rd, RD[i*48 +: 32]);
        end
        for (i = 0; i < 6; i = i + 1) begin
            acc(1'b1, RO[i*16 +: 16], 32'h5a5a5a5a);
            check({30'h0, fl}, 32'h00000003);
        end
        acc(1'b0, 16'h6501, 32'h00000000);
        check(rd, 32'h00002000);
        acc(1'b0, 16'h6005, 32'h00000000);
        check({fl, rd[29:0]}, 32'h40000000);
        acc(1'b1, 16'h6005, 32'h00000000);
        check({30'h0, fl}, 32'h00000003);
        wait_pos(32'h00012345);
        acc(1'b1, 16'h6000, 32'h00000001);
        wait_pos(32'h01ffffff - 32'h00012345);
        acc(1'b1, 16'h6000, 32'h0000fffe);
        wait_pos(32'h00012345);
        acc(1'b0, 16'h6500, 32'h00000000);
        check(rd, 32'h0000fffe);
        // values chosen within resolution and dividing evenly
        acc(1'b1, 16'h6001, 32'h00001000);
        acc(1'b1, 16'h6002, 32'h00800000);
        acc(1'b1, 16'h6000, 32'h00000000);
        slow = 1'b1;
        wait_pos(32'h000091a2);
        slow = 1'b0;
        acc(1'b1, 16'h6003, 32'h007fffff);
        wait_pos(32'h007fffff);
        acc(1'b0, 16'h6509, 32'h00000000);
        check(rd, 32'h000091a3);
        raw_count = 32'h00012347;
        wait_pos(32'h00000000);
        stall = 1'b1;
        repeat (400) @(posedge clk);
        #1;
        check({31'h0, pos_valid}, 32'h00000001);
        raw_count = 32'h00012345;
        stall = 1'b0;
        wait_pos(32'h007fffff);
        acc(1'b0, 16'h6004, 32'h00000000);
        check(rd, 32'h007fffff);
        acc(1'b1, 16'h1010, `SIG_STORE);
        check({30'h0, fl}, 32'h00000002);
        check({30'h0, sv}, 32'h00000001);
        acc(1'b1, 16'h1010, 32'h12345678);
        check({30'h0, fl}, 32'h00000003);
        check({30'h0, sv}, 32'h00000000);
        acc(1'b1, 16'h1011, `SIG_RESTORE);
        check({30'h0, fl}, 32'h00000002);
        check({30'h0, sv}, 32'h00000003);
        for (i = 4; i >= 0; i = i - 1) begin
            acc(1'b0, RS[i*48+32 +: 16], 32'h00000000);
            check(rd, RS[i*48 +: 32]);
        end
        tally_and_finish;
    end
endmodule
